/* pmc_regs.sv */
// management-frame slave holding the basic control and status registers
// Behaviour
// - control bit 11 set puts the core into software power-down; mirrored out
// - management reads and writes keep working while powered down
// - power-down bit takes its reset value from the strap pin
// - isolate bit is read/write, resets to zero, detaches the MII
// - duplex-mode bit ignores writes, reads 1
// - collision-test bit ignores writes, reads 0
// - both speed-select bits ignore writes, read 00
// - one-way transmit enable ignores writes, reads 0
// - unsupported technology ability bits in status always read 0
// - ten-megabit full-duplex ability bit reads 1
// - extended-status-present bit always reads 0
// - one-way transmit ability bit always reads 0
// - preamble-skip ability reads 0; every frame needs its preamble
// - negotiation-done flag mirrors the internal flag directly, with no reset of its own
// - far-fault flag always reads 0
// - negotiation ability bit always reads 1
// - link-up bit latches low once the link fails
// - reading status releases the latched-low link bit
// - babble-detect flag always reads 0
// - extended-registers-present bit always reads 1
// - status register lives at address one, resets to 0x1009
`default_nettype none
`include "pmc_params.svh"

module pmc_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter int PRE_LEN = `PMC_PRE_LEN
) (
  input wire logic clock, // 40 MHz device clock
  input wire logic reset, // async, active high
  input wire logic mdc, // management clock, sampled
  input wire logic mdio_in, // management data pin level
  output logic mdio_out, // management data driven value
  output logic mdio_oe, // high while driving the data pin
  input wire logic powerdown_strap_pin, // power-down default strap
  input wire logic internal_negotiation_done, // negotiation finished, link up
  input wire logic internal_link_state, // current link status
  output pmc_pkg::pmc_ctrl_s core_ctrl // power-down and isolate controls
);

  if (PRE_LEN < 1 || PRE_LEN > 63) begin : g_bad_pre
    $error("PRE_LEN out of range");
  end

  pmc_pkg::pmc_state_e state_r;
  logic mdc_d_r;
  logic [5:0] pre_cnt_r;
  logic [3:0] bit_cnt_r;
  logic [10:0] hdr_r;
  logic [4:0] reg_addr_r;
  logic is_read_r;
  logic [15:0] shift_r;
  logic strap_done_r;
  logic link_latch_r;
  logic mdc_rise;
  logic [11:0] hdr_full;
  logic [15:0] wdata;
  logic read_cap;
  logic stat_read;
  logic ctrl_write;

  function automatic logic [15:0] pmc_read_word(
    input logic [4:0] addr,
    input pmc_pkg::pmc_ctrl_s c,
    input logic an_done,
    input logic link
  );
    logic [15:0] w;
    w = `PMC_UNMAPPED_DATA;
    if (addr == `PMC_ADDR_CTRL) begin
      w = `PMC_CTRL_FIXED;
      w[`PMC_CTRL_PD_BIT] = c.core_powerdown_request;
      w[`PMC_CTRL_ISO_BIT] = c.mii_detach_ctl;
    end else if (addr == `PMC_ADDR_STAT) begin
      w = `PMC_STAT_FIXED;
      w[`PMC_STAT_AND_BIT] = an_done;
      w[`PMC_STAT_LINK_BIT] = link;
    end
    return w;
  endfunction

  // pin inputs are synchronous to clock, so a single delay finds the edge
  assign mdc_rise = mdc & ~mdc_d_r;
  assign hdr_full = {hdr_r, mdio_in};
  assign wdata = {shift_r[14:0], mdio_in};
  assign read_cap = (state_r == pmc_pkg::st_ta) && mdc_rise && is_read_r &&
                    (bit_cnt_r == 4'h0);
  assign stat_read = read_cap && (reg_addr_r == `PMC_ADDR_STAT);
  assign ctrl_write = (state_r == pmc_pkg::st_wdata) && mdc_rise &&
                      (bit_cnt_r == `PMC_DATA_LAST) && (reg_addr_r == `PMC_ADDR_CTRL);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mdc_d_r <= 1'b0;
    end else begin
      mdc_d_r <= mdc;
    end
  end

  // frame sequencer; runs regardless of power-down
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= pmc_pkg::st_idle;
      pre_cnt_r <= 6'h00;
      bit_cnt_r <= 4'h0;
      hdr_r <= 11'h000;
      reg_addr_r <= 5'h00;
      is_read_r <= 1'b0;
    end else if (mdc_rise) begin
      unique case (state_r)
        pmc_pkg::st_idle: begin
          if (mdio_in) begin
            if (pre_cnt_r != 6'h3f) begin
              pre_cnt_r <= pre_cnt_r + 6'h01;
            end
          end else begin
            // a frame without the full preamble is not received
            if (pre_cnt_r >= 6'(PRE_LEN)) begin
              state_r <= pmc_pkg::st_start;
            end
            pre_cnt_r <= 6'h00;
          end
        end
        pmc_pkg::st_start: begin
          bit_cnt_r <= 4'h0;
          state_r <= mdio_in ? pmc_pkg::st_hdr : pmc_pkg::st_idle;
        end
        pmc_pkg::st_hdr: begin
          hdr_r <= hdr_full[10:0];
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == `PMC_HDR_LAST) begin
            bit_cnt_r <= 4'h0;
            reg_addr_r <= hdr_full[4:0];
            is_read_r <= (hdr_full[11:10] == `PMC_OP_READ);
            if (hdr_full[9:5] == PHY_ADDR &&
                (hdr_full[11:10] == `PMC_OP_READ || hdr_full[11:10] == `PMC_OP_WRITE)) begin
              state_r <= pmc_pkg::st_ta;
            end else begin
              state_r <= pmc_pkg::st_idle;
            end
          end
        end
        pmc_pkg::st_ta: begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == `PMC_TA_LAST) begin
            bit_cnt_r <= 4'h0;
            state_r <= is_read_r ? pmc_pkg::st_rdata : pmc_pkg::st_wdata;
          end
        end
        pmc_pkg::st_rdata, pmc_pkg::st_wdata: begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == `PMC_DATA_LAST) begin
            bit_cnt_r <= 4'h0;
            state_r <= pmc_pkg::st_idle;
          end
        end
      endcase
    end
  end

  // data shifter: read word loaded during turnaround, write word shifted in
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shift_r <= 16'h0000;
    end else if (read_cap) begin
      shift_r <= pmc_read_word(reg_addr_r, core_ctrl, internal_negotiation_done,
                               link_latch_r);
    end else if (mdc_rise && state_r == pmc_pkg::st_ta && bit_cnt_r == `PMC_TA_LAST &&
                 is_read_r) begin
      shift_r <= {shift_r[14:0], 1'b0};
    end else if (mdc_rise && state_r == pmc_pkg::st_rdata) begin
      shift_r <= {shift_r[14:0], 1'b0};
    end else if (mdc_rise && state_r == pmc_pkg::st_wdata) begin
      shift_r <= wdata;
    end
  end

  // pin drive: changes just after the rising edge, host samples the next one
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mdio_oe <= 1'b0;
      mdio_out <= 1'b0;
    end else if (mdc_rise) begin
      if (read_cap) begin
        mdio_oe <= 1'b1;
        mdio_out <= 1'b0;
      end else if (state_r == pmc_pkg::st_ta && is_read_r) begin
        mdio_out <= shift_r[15];
      end else if (state_r == pmc_pkg::st_rdata) begin
        if (bit_cnt_r == `PMC_DATA_LAST) begin
          mdio_oe <= 1'b0;
          mdio_out <= 1'b0;
        end else begin
          mdio_out <= shift_r[15];
        end
      end
    end
  end

  // strap caught on the first edge after release, never under reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      strap_done_r <= 1'b0;
      core_ctrl.core_powerdown_request <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      core_ctrl.core_powerdown_request <= powerdown_strap_pin;
    end else if (ctrl_write) begin
      core_ctrl.core_powerdown_request <= wdata[`PMC_CTRL_PD_BIT];
    end
  end

  // other control bits are fixed, so a write only touches these two
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      core_ctrl.mii_detach_ctl <= 1'b0;
    end else if (ctrl_write) begin
      core_ctrl.mii_detach_ctl <= wdata[`PMC_CTRL_ISO_BIT];
    end
  end

  // failure beats the read release, so a drop during a read is not lost
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      link_latch_r <= 1'b0;
    end else if (!internal_link_state) begin
      link_latch_r <= 1'b0;
    end else if (stat_read) begin
      link_latch_r <= 1'b1;
    end
  end

  pd_write_a: assert property (@(posedge clock) disable iff (reset)
    ctrl_write && strap_done_r |=>
    core_ctrl.core_powerdown_request == $past(wdata[`PMC_CTRL_PD_BIT]))
    else $error("power-down bit did not follow write");

  strap_load_a: assert property (@(posedge clock) disable iff (reset)
    $rose(strap_done_r) |-> core_ctrl.core_powerdown_request == $past(powerdown_strap_pin))
    else $error("power-down default not taken from strap");

  iso_write_a: assert property (@(posedge clock) disable iff (reset)
    ctrl_write |=> core_ctrl.mii_detach_ctl == $past(wdata[`PMC_CTRL_ISO_BIT]))
    else $error("isolate bit did not follow write");

  pd_mdio_alive_a: assert property (@(posedge clock) disable iff (reset)
    read_cap && core_ctrl.core_powerdown_request |=> mdio_oe && !mdio_out)
    else $error("no read turnaround while powered down");

  ctrl_fixed_a: assert property (@(posedge clock) disable iff (reset)
    read_cap && reg_addr_r == `PMC_ADDR_CTRL |=>
    (shift_r & `PMC_CTRL_FIXED_MASK) == `PMC_CTRL_FIXED)
    else $error("control fixed bits wrong");

  stat_fixed_a: assert property (@(posedge clock) disable iff (reset)
    stat_read |=> (shift_r & `PMC_STAT_FIXED_MASK) == `PMC_STAT_FIXED)
    else $error("status fixed bits wrong");

  link_latch_a: assert property (@(posedge clock) disable iff (reset)
    !internal_link_state |=> !link_latch_r ##1 (!link_latch_r || $past(stat_read)))
    else $error("link bit not latched low");

  link_release_a: assert property (@(posedge clock) disable iff (reset)
    stat_read && internal_link_state ##1 internal_link_state |-> link_latch_r)
    else $error("status read did not release link bit");

  read_release_a: assert property (@(posedge clock) disable iff (reset)
    mdc_rise && state_r == pmc_pkg::st_rdata && bit_cnt_r == `PMC_DATA_LAST |=> !mdio_oe)
    else $error("data pin not released after read");

  // only a control write may move the control outputs once the strap is in
  ctrl_hold_a: assert property (@(posedge clock) disable iff (reset)
    strap_done_r && !ctrl_write |=> $stable(core_ctrl))
    else $error("control bits changed without a control write");

  pre_gate_a: assert property (@(posedge clock) disable iff (reset)
    mdc_rise && state_r == pmc_pkg::st_idle && !mdio_in && pre_cnt_r < 6'(PRE_LEN)
    |=> state_r == pmc_pkg::st_idle)
    else $error("frame started without full preamble");

  oe_window_a: assert property (@(posedge clock) disable iff (reset)
    mdio_oe |-> state_r == pmc_pkg::st_ta || state_r == pmc_pkg::st_rdata)
    else $error("data pin driven outside a read");

  unmapped_zero_a: assert property (@(posedge clock) disable iff (reset)
    read_cap && reg_addr_r == `PMC_ADDR_EXT_STAT |=> shift_r == `PMC_UNMAPPED_DATA)
    else $error("missing extended status register did not read zero");

  ctrl_write_c: cover property (@(posedge clock) disable iff (reset) ctrl_write);
  stat_read_c: cover property (@(posedge clock) disable iff (reset) stat_read);
  link_drop_c: cover property (@(posedge clock) disable iff (reset)
    link_latch_r ##1 !link_latch_r);
  pd_read_c: cover property (@(posedge clock) disable iff (reset)
    read_cap && core_ctrl.core_powerdown_request);
  short_pre_c: cover property (@(posedge clock) disable iff (reset)
    mdc_rise && state_r == pmc_pkg::st_idle && !mdio_in && pre_cnt_r != 6'h00 &&
    pre_cnt_r < 6'(PRE_LEN));

endmodule
`default_nettype wire

/* pmc_params.svh */
// constants for the basic management registers and the management frame
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// register addresses
`define PMC_ADDR_CTRL 5'h00
`define PMC_ADDR_STAT 5'h01
`define PMC_ADDR_EXT_STAT 5'h0f

// control register fields
`define PMC_CTRL_PD_BIT 11
`define PMC_CTRL_ISO_BIT 10
`define PMC_CTRL_FIXED 16'h0100
`define PMC_CTRL_FIXED_MASK 16'hf3ff

// status register fields
`define PMC_STAT_AND_BIT 5
`define PMC_STAT_LINK_BIT 2
`define PMC_STAT_FIXED 16'h1009
`define PMC_STAT_FIXED_MASK 16'hffdb
`define PMC_STAT_RESET 16'h1009

// value returned for an address with no register
`define PMC_UNMAPPED_DATA 16'h0000

// frame fields
`define PMC_PRE_LEN 32
`define PMC_OP_READ 2'b10
`define PMC_OP_WRITE 2'b01
`define PMC_HDR_LAST 4'hb
`define PMC_DATA_LAST 4'hf
`define PMC_TA_LAST 4'h1

`endif

/* pmc_pkg.sv */
// types for the basic management register block
`default_nettype none
package pmc_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_start,
    st_hdr,
    st_ta,
    st_rdata,
    st_wdata
  } pmc_state_e;

  typedef struct packed {
    logic core_powerdown_request;
    logic mii_detach_ctl;
  } pmc_ctrl_s;

endpackage
`default_nettype wire

/* pmc_host.sv */
// station management host model that clocks frames onto the data wire
`default_nettype none
module pmc_host (
  input wire logic clock, // bench clock
  output logic mdc, // management clock, still between frames
  output logic mdio_drv, // host level, 1 when released
  input wire logic mdio_wire // resolved wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] smp;

  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
  end

  // wire sampled just before each rise, so it holds what the device drove after the last one
  task automatic clk_bit(input logic b);
    mdc = 1'b0;
    mdio_drv = b;
    repeat (2) @(negedge clock);
    smp = {smp[62:0], mdio_wire};
    mdc = 1'b1;
    repeat (2) @(negedge clock);
  endtask

  // reads pass 16'hffff so the host stays released and the pull-up level shows
  task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] bits;
    bits = {2'b01, op, 5'h00, ra, (op == 2'b10) ? 2'b11 : 2'b10, wd};
    for (int i = 0; i < pre; i++) begin
      clk_bit(1'b1);
    end
    for (int i = 31; i >= 0; i--) begin
      clk_bit(bits[i]);
    end
    mdc = 1'b0;
    mdio_drv = 1'b1;
    @(negedge clock);
    rd = smp[15:0];
  endtask
endmodule
`default_nettype wire

/* test_phy_mii_ctrl_status_regs.sv */
// self-checking bench for the basic control and status registers
`default_nettype none
`include "pmc_params.svh"
module test_phy_mii_ctrl_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, strap, an_done, link, mdc, host_v, mdio_out, mdio_oe, mdio_wire;
  pmc_pkg::pmc_ctrl_s core_ctrl;
  logic [15:0] rd;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // pulled-up wire: host level wins only while the device is not driving
  assign mdio_wire = mdio_oe ? mdio_out : host_v;

  pmc_regs u_dut (.clock(clock), .reset(reset), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .powerdown_strap_pin(strap),
    .internal_negotiation_done(an_done), .internal_link_state(link), .core_ctrl(core_ctrl));
  pmc_host u_host (.clock(clock), .mdc(mdc), .mdio_drv(host_v), .mdio_wire(mdio_wire));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    u_host.frame(32, 2'b10, ra, 16'hffff, rd);
    check(rd, exp);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    u_host.frame(32, 2'b01, ra, wd, rd);
  endtask

  task automatic do_reset(input logic s);
    strap = s;
    reset = 1'b1;
    repeat (20) @(negedge clock);
    reset = 1'b0;
    repeat (2) @(negedge clock);
  endtask

  task automatic test_done;
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // about 20 frames of roughly 260 cycles each, plus two resets
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    reset = 1'b1;
    strap = 1'b1;
    an_done = 1'b0;
    link = 1'b0;
    do_reset(1'b1);
    rd_chk(`PMC_ADDR_STAT, 16'h1009);
    rd_chk(`PMC_ADDR_CTRL, 16'h0900);
    check({14'h0000, core_ctrl}, 16'h0002);
    wr(`PMC_ADDR_CTRL, 16'hffff);
    rd_chk(`PMC_ADDR_CTRL, 16'h0d00);
    check({14'h0000, core_ctrl}, 16'h0003);
    wr(`PMC_ADDR_CTRL, 16'h0400);
    rd_chk(`PMC_ADDR_CTRL, 16'h0500);
    check({14'h0000, core_ctrl}, 16'h0001);
    // short preamble: the frame must be dropped
    u_host.frame(8, 2'b01, `PMC_ADDR_CTRL, 16'h0800, rd);
    rd_chk(`PMC_ADDR_CTRL, 16'h0500);
    // undefined operation code: the frame must be ignored as a whole
    u_host.frame(32, 2'b11, `PMC_ADDR_CTRL, 16'h0800, rd);
    rd_chk(`PMC_ADDR_CTRL, 16'h0500);
    check({14'h0000, core_ctrl}, 16'h0001);
    wr(`PMC_ADDR_STAT, 16'hffff);
    rd_chk(`PMC_ADDR_STAT, 16'h1009);
    rd_chk(`PMC_ADDR_EXT_STAT, 16'h0000);
    link = 1'b1;
    rd_chk(`PMC_ADDR_STAT, 16'h1009);
    rd_chk(`PMC_ADDR_STAT, 16'h100d);
    an_done = 1'b1;
    rd_chk(`PMC_ADDR_STAT, 16'h102d);
    link = 1'b0;
    repeat (3) @(negedge clock);
    link = 1'b1;
    rd_chk(`PMC_ADDR_STAT, 16'h1029);
    rd_chk(`PMC_ADDR_STAT, 16'h102d);
    an_done = 1'b0;
    do_reset(1'b0);
    rd_chk(`PMC_ADDR_CTRL, 16'h0100);
    check({14'h0000, core_ctrl}, 16'h0000);
    rd_chk(`PMC_ADDR_STAT, 16'h1009);
    test_done();
  end
endmodule
`default_nettype wire
